// [hw/cdcp_control_port.sv]
/*
  Dual control port: two-wire slave sampled on mclk, four-wire slave on
  its own serial clock, one shared subaddress engine on mclk.
  Assumes the register space answers reg_rdata_i combinationally for
  reg_req_o.addr and byte_idx, on mclk.
*/
// Summary of operation
// [RULE_01] Two-wire side only answers; it never starts a transfer.
// [RULE_02] Address byte is 01110, two select pin levels, then direction.
// [RULE_03] Direction one reads from the device, zero writes to it.
// [RULE_04] Start is data falling while clock high; address stream follows.
// [RULE_05] Eight bits MSB first; matching address acked on ninth clock.
// [RULE_06] Transfer lasts until stop: data rising while clock high.
// [RULE_07] Start or stop anywhere aborts to idle or restarts addressing.
// [RULE_08] Master gives at most one start, one stop, or stop-start per high.
// [RULE_09] Invalid subaddress is not acknowledged; port returns to idle.
// [RULE_10] Reads past top keep returning top register until master nacks.
// [RULE_11] Writes past top are dropped, not acknowledged, port goes idle.
// [RULE_12] Write is address, subaddress high, low, data; each byte acked.
// [RULE_13] Read: write subaddress, repeated start, address with read bit.
// [RULE_14] Master acks each read byte and ends with a nack.
// [RULE_15] Address advances after a full word of that location's length.
// [RULE_16] Starts two-wire; three latch pulses switch to four-wire mode.
// [RULE_17] Four-wire mode holds until reset.
// [RULE_18] Host frames each four-wire transaction with latch low.
// [RULE_19] Input sampled on rising clock, output shifted on falling, MSB first.
// [RULE_20] Serial output stays undriven until a read is requested.
// [RULE_21] Four-wire first byte is seven zeros then direction bit.
// [RULE_22] Sixteen-bit subaddress in two bytes; burst fills next locations.
// [RULE_23] Auto-increment runs until stop or latch high.
// [RULE_24] All words one byte except the six-byte clock synth register.
// [RULE_25] Holes advance the address, ignore writes, read as zero.
// [RULE_26] Four-wire read output starts driving with the first data byte.
// [RULE_27] Accesses reach the register space as address, data, strobe, on mclk.
`timescale 1ns/10ps
`default_nettype none

module cdcp_control_port (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Two-wire pins
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_i,
  output logic i2c_sda_o,
  output logic i2c_sda_oe_o,
  input wire logic addr_select_hi_pin_i,
  input wire logic addr_select_lo_pin_i,
  // Four-wire pins
  input wire logic four_wire_clock_i,
  input wire logic four_wire_latch_i,
  input wire logic four_wire_serial_in_i,
  output logic four_wire_serial_out_o,
  output logic four_wire_serial_out_oe_o,
  // Register space
  output cdcp_pkg::cdcp_reg_req_t reg_req_o,
  input wire logic [7:0] reg_rdata_i,
  // Status
  output logic four_wire_mode_o
);

  // ****************************************
  // Decoders
  // ****************************************
  function automatic logic is_hole(input logic [15:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < cdcp_pkg::HOLE_COUNT; i++)
    begin
      hit = hit || (a >= cdcp_pkg::HOLE_LO[i] && a <= cdcp_pkg::HOLE_HI[i]);
    end
    return hit;
  endfunction : is_hole

  function automatic logic [2:0] word_len(input logic [15:0] a);
    return (a == cdcp_pkg::PLL_CTRL_ADDR) ? cdcp_pkg::PLL_CTRL_LEN :
      cdcp_pkg::WORD_LEN_ONE; // RULE_24
  endfunction : word_len

  // ****************************************
  // Pin synchronisers on mclk
  // ****************************************
  logic [4:0] pin_meta, pin_sync, pin_last;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_meta <= 5'h1f;
      pin_sync <= 5'h1f;
      pin_last <= 5'h1f;
    end
    else
    begin
      pin_meta <= {i2c_scl_i, i2c_sda_i, addr_select_hi_pin_i,
        addr_select_lo_pin_i, four_wire_latch_i};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  logic mode, scl, sda, scl_rise, scl_fall, start_cond, stop_cond, latch_rise;

  assign scl = pin_sync[4];
  assign sda = pin_sync[3];
  assign scl_rise = scl && !pin_last[4];
  assign scl_fall = !scl && pin_last[4];
  assign start_cond = scl && pin_last[4] && pin_last[3] && !sda; // RULE_04
  assign stop_cond = scl && pin_last[4] && !pin_last[3] && sda; // RULE_06
  assign latch_rise = pin_sync[0] && !pin_last[0];

  // ****************************************
  // Mode switch
  // ****************************************
  // Counting completed low pulses means the third dummy frame is still
  // ignored; only the fourth one finds the mode set.
  logic [1:0] latch_cnt;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      latch_cnt <= 2'h0;
      mode <= 1'b0;
    end
    else if (latch_rise && !mode)
    begin
      latch_cnt <= latch_cnt + 2'h1;
      if (latch_cnt == cdcp_pkg::LATCH_PULSES - 2'h1)
      begin
        mode <= 1'b1; // RULE_16 RULE_17
      end
    end
  end

  assign four_wire_mode_o = mode;

  // ****************************************
  // Shared subaddress engine
  // ****************************************
  cdcp_pkg::cdcp_reg_req_t req;
  logic adv_pend, adv_rd, fetch_pend, past_top, set_ev, wr_ev, rd_ev;
  logic i2c_set, i2c_wr, i2c_adv, spi_set, spi_wr, spi_adv;
  logic [7:0] tx_hold, wr_val, i2c_rx, spi_wdata;
  logic [15:0] set_val, i2c_sub, spi_sub;

  assign past_top = req.addr > cdcp_pkg::TOP_SUBADDR;
  assign set_ev = i2c_set || spi_set;
  assign wr_ev = i2c_wr || spi_wr;
  assign rd_ev = i2c_adv || spi_adv;
  assign set_val = mode ? spi_sub : i2c_sub;
  assign wr_val = mode ? spi_wdata : i2c_rx;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      req <= '0;
      adv_pend <= 1'b0;
      adv_rd <= 1'b0;
      fetch_pend <= 1'b0;
      tx_hold <= 8'h00;
    end
    else
    begin
      req.wr <= 1'b0;
      if (set_ev)
      begin
        req.addr <= set_val; // RULE_22
        req.byte_idx <= 3'h0;
        fetch_pend <= 1'b1;
      end
      else if (wr_ev)
      begin
        req.wr <= !is_hole(req.addr); // RULE_25 RULE_27
        req.wdata <= wr_val;
        adv_pend <= 1'b1;
        adv_rd <= 1'b0;
      end
      else if (rd_ev)
      begin
        adv_pend <= 1'b1;
        adv_rd <= 1'b1;
      end
      else if (adv_pend)
      begin
        adv_pend <= 1'b0;
        fetch_pend <= 1'b1;
        if (req.byte_idx + 3'h1 < word_len(req.addr))
        begin
          req.byte_idx <= req.byte_idx + 3'h1; // RULE_15
        end
        else
        begin
          req.byte_idx <= 3'h0;
          if (!(adv_rd && req.addr >= cdcp_pkg::TOP_SUBADDR))
          begin
            req.addr <= req.addr + 16'h0001; // RULE_10 RULE_23
          end
        end
      end
      else if (fetch_pend)
      begin
        fetch_pend <= 1'b0;
        tx_hold <= is_hole(req.addr) ? cdcp_pkg::HOLE_DATA :
          reg_rdata_i; // RULE_25
      end
    end
  end

  assign reg_req_o = req;

  // ****************************************
  // Two-wire slave
  // ****************************************
  // Slave only: the data line is released except for acks and read bits,
  // and every change is made after a clock fall.
  cdcp_pkg::cdcp_i2c_state_t ist;
  cdcp_pkg::cdcp_byte_kind_t kind;
  logic [3:0] bitcnt;
  logic [7:0] sub_hi, txs;
  logic is_read, macked, sda_oe, byte_done, addr_hit, refuse;

  assign byte_done = ist == cdcp_pkg::I_RECV && scl_fall &&
    bitcnt == cdcp_pkg::BITS_PER_BYTE;
  assign addr_hit = i2c_rx[7:1] == {cdcp_pkg::I2C_ADDR_FIXED,
    pin_sync[2], pin_sync[1]}; // RULE_02
  assign i2c_sub = {sub_hi, i2c_rx};
  assign i2c_set = byte_done && kind == cdcp_pkg::K_SUBL &&
    i2c_sub <= cdcp_pkg::TOP_SUBADDR;
  assign i2c_wr = byte_done && kind == cdcp_pkg::K_DATA && !past_top;
  assign i2c_adv = ist == cdcp_pkg::I_MACK && scl_rise && !sda; // RULE_14
  assign refuse = kind == cdcp_pkg::K_ADDR ? !addr_hit : // RULE_05
    kind == cdcp_pkg::K_SUBL ? i2c_sub > cdcp_pkg::TOP_SUBADDR : // RULE_09
    kind == cdcp_pkg::K_DATA && past_top; // RULE_11

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ist <= cdcp_pkg::I_IDLE;
      kind <= cdcp_pkg::K_ADDR;
      bitcnt <= 4'h0;
      i2c_rx <= 8'h00;
      sub_hi <= 8'h00;
      txs <= 8'h00;
      is_read <= 1'b0;
      macked <= 1'b0;
      sda_oe <= 1'b0;
      i2c_sda_o <= 1'b0; // Open drain: only ever pulls low
    end
    else if (mode)
    begin
      ist <= cdcp_pkg::I_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_cond)
    begin
      ist <= cdcp_pkg::I_RECV; // RULE_07
      kind <= cdcp_pkg::K_ADDR;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (stop_cond)
    begin
      ist <= cdcp_pkg::I_IDLE; // RULE_07 RULE_23
      sda_oe <= 1'b0;
    end
    else
    begin
      case (ist)
        cdcp_pkg::I_IDLE:
        begin
          sda_oe <= 1'b0; // RULE_01
        end
        cdcp_pkg::I_RECV:
        begin
          if (scl_rise && bitcnt < cdcp_pkg::BITS_PER_BYTE)
          begin
            i2c_rx <= {i2c_rx[6:0], sda}; // RULE_05
            bitcnt <= bitcnt + 4'h1;
          end
          if (byte_done)
          begin
            ist <= refuse ? cdcp_pkg::I_IDLE : cdcp_pkg::I_ACK; // RULE_12
            sda_oe <= !refuse;
            if (kind == cdcp_pkg::K_ADDR)
              is_read <= i2c_rx[0]; // RULE_03
            if (kind == cdcp_pkg::K_SUBH)
              sub_hi <= i2c_rx;
          end
        end
        cdcp_pkg::I_ACK:
        begin
          if (scl_fall)
          begin
            if (kind == cdcp_pkg::K_ADDR && is_read)
            begin
              ist <= cdcp_pkg::I_SEND; // RULE_13
              txs <= tx_hold;
              sda_oe <= !tx_hold[7];
              bitcnt <= 4'h1;
            end
            else
            begin
              ist <= cdcp_pkg::I_RECV;
              bitcnt <= 4'h0;
              sda_oe <= 1'b0;
              case (kind)
                cdcp_pkg::K_ADDR: kind <= cdcp_pkg::K_SUBH;
                cdcp_pkg::K_SUBH: kind <= cdcp_pkg::K_SUBL;
                default: kind <= cdcp_pkg::K_DATA;
              endcase
            end
          end
        end
        cdcp_pkg::I_SEND:
        begin
          if (scl_fall)
          begin
            if (bitcnt == cdcp_pkg::BITS_PER_BYTE)
            begin
              ist <= cdcp_pkg::I_MACK;
              sda_oe <= 1'b0;
            end
            else
            begin
              sda_oe <= !txs[6];
              txs <= {txs[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        cdcp_pkg::I_MACK:
        begin
          if (scl_rise)
          begin
            macked <= !sda;
          end
          if (scl_fall)
          begin
            if (macked)
            begin
              ist <= cdcp_pkg::I_SEND; // RULE_10
              txs <= tx_hold;
              sda_oe <= !tx_hold[7];
              bitcnt <= 4'h1;
            end
            else
            begin
              ist <= cdcp_pkg::I_IDLE; // RULE_14
            end
          end
        end
        default:
        begin
          ist <= cdcp_pkg::I_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  assign i2c_sda_oe_o = sda_oe;

  // ****************************************
  // Four-wire slave on the serial clock
  // ****************************************
  // The latch high level clears the whole frame, so nothing depends on
  // clock edges outside a frame.
  logic lk_rst_n, lk_rd, lk_bad, lk_reading;
  logic [2:0] lk_bit, lk_tgl;
  logic [1:0] lk_byte, lk_mode_s;
  logic [6:0] lk_shift, lk_oshift;
  logic [7:0] lk_byte_val;

  assign lk_rst_n = reset_n_i && !four_wire_latch_i; // RULE_18
  assign lk_byte_val = {lk_shift, four_wire_serial_in_i};

  always_ff @(posedge four_wire_clock_i or negedge lk_rst_n)
  begin
    if (!lk_rst_n)
    begin
      lk_bit <= 3'h0;
      lk_byte <= 2'h0;
      lk_shift <= 7'h00;
      lk_rd <= 1'b0;
      lk_bad <= 1'b0;
      lk_mode_s <= 2'h0;
    end
    else
    begin
      lk_mode_s <= {lk_mode_s[0], mode};
      lk_shift <= lk_byte_val[6:0]; // RULE_19
      lk_bit <= lk_bit + 3'h1;
      if (lk_bit == cdcp_pkg::LAST_BIT)
      begin
        if (lk_byte != cdcp_pkg::DATA_BYTE_IDX)
        begin
          lk_byte <= lk_byte + 2'h1;
        end
        if (lk_byte == 2'h0)
        begin
          lk_rd <= lk_byte_val[0];
          lk_bad <= lk_byte_val[7:1] != cdcp_pkg::SPI_CHIP_ADDR; // RULE_21
        end
      end
    end
  end

  // Words cross to mclk held stable while a toggle announces them
  always_ff @(posedge four_wire_clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lk_tgl <= 3'h0;
      spi_sub <= 16'h0000;
      spi_wdata <= 8'h00;
    end
    else if (!four_wire_latch_i && lk_bit == cdcp_pkg::LAST_BIT && !lk_bad)
    begin
      if (lk_byte == 2'h1)
      begin
        spi_sub[15:8] <= lk_byte_val;
      end
      else if (lk_byte == 2'h2)
      begin
        spi_sub[7:0] <= lk_byte_val;
        lk_tgl[0] <= !lk_tgl[0]; // RULE_22
      end
      else if (lk_byte == cdcp_pkg::DATA_BYTE_IDX)
      begin
        if (lk_rd)
        begin
          lk_tgl[2] <= !lk_tgl[2];
        end
        else
        begin
          spi_wdata <= lk_byte_val;
          lk_tgl[1] <= !lk_tgl[1];
        end
      end
    end
  end

  assign lk_reading = lk_byte == cdcp_pkg::DATA_BYTE_IDX && lk_rd &&
    !lk_bad && lk_mode_s[1];

  always_ff @(negedge four_wire_clock_i or negedge lk_rst_n)
  begin
    if (!lk_rst_n)
    begin
      four_wire_serial_out_o <= 1'b0;
      four_wire_serial_out_oe_o <= 1'b0; // RULE_20
      lk_oshift <= 7'h00;
    end
    else if (lk_reading)
    begin
      four_wire_serial_out_oe_o <= 1'b1; // RULE_26
      if (lk_bit == 3'h0)
      begin
        four_wire_serial_out_o <= tx_hold[7]; // RULE_19
        lk_oshift <= tx_hold[6:0];
      end
      else
      begin
        four_wire_serial_out_o <= lk_oshift[6];
        lk_oshift <= {lk_oshift[5:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Four-wire events into mclk
  // ****************************************
  logic [2:0] tg_meta, tg_sync, tg_last;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tg_meta <= 3'h0;
      tg_sync <= 3'h0;
      tg_last <= 3'h0;
    end
    else
    begin
      tg_meta <= lk_tgl;
      tg_sync <= tg_meta;
      tg_last <= tg_sync;
    end
  end

  // Frames before the mode switch are dummies and never reach the space
  assign spi_set = mode && (tg_sync[0] ^ tg_last[0]); // RULE_16
  assign spi_wr = mode && (tg_sync[1] ^ tg_last[1]) && !past_top;
  assign spi_adv = mode && (tg_sync[2] ^ tg_last[2]);

endmodule : cdcp_control_port

`default_nettype wire

// [hw/cdcp_pkg.sv]
/*
  Constants, types and state enumerations for the codec control port.
  Assumes a 16-bit internal register space reached one byte at a time.
*/
`default_nettype none

package cdcp_pkg;

  // ****************************************
  // Addressing
  // ****************************************
  localparam logic [4:0] I2C_ADDR_FIXED = 5'h0e;
  localparam logic [6:0] SPI_CHIP_ADDR = 7'h00;
  localparam logic [15:0] PLL_CTRL_ADDR = 16'h4002;
  localparam logic [2:0] PLL_CTRL_LEN = 3'h6;
  localparam logic [2:0] WORD_LEN_ONE = 3'h1;
  localparam logic [15:0] TOP_SUBADDR = 16'h40ff;
  localparam logic [7:0] HOLE_DATA = 8'h00;
  localparam int HOLE_COUNT = 9;
  localparam logic [HOLE_COUNT-1:0][15:0] HOLE_LO = {
    16'h4001, 16'h4003, 16'h402e, 16'h4032, 16'h4037,
    16'h40c5, 16'h40ca, 16'h40d5, 16'h40ec};
  localparam logic [HOLE_COUNT-1:0][15:0] HOLE_HI = {
    16'h4001, 16'h4007, 16'h402e, 16'h4035, 16'h40bf,
    16'h40c5, 16'h40cf, 16'h40ea, 16'h40f1};

  // ****************************************
  // Framing counts
  // ****************************************
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] LATCH_PULSES = 2'h3;
  localparam logic [1:0] DATA_BYTE_IDX = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    I_IDLE, I_RECV, I_ACK, I_SEND, I_MACK
  } cdcp_i2c_state_t;

  typedef enum logic [1:0] {
    K_ADDR, K_SUBH, K_SUBL, K_DATA
  } cdcp_byte_kind_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [2:0] byte_idx;
    logic [7:0] wdata;
    logic wr;
  } cdcp_reg_req_t;

endpackage : cdcp_pkg

`default_nettype wire

// [sim/cdcp_control_port_sva.sv]
/*
  Port checker of the codec control port.
  Assumes it is bound to every cdcp_control_port instance.
*/
`timescale 1ns/10ps
`default_nettype none

module cdcp_control_port_sva (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Two-wire pins
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_i,
  input wire logic i2c_sda_o,
  input wire logic i2c_sda_oe_o,
  input wire logic addr_select_hi_pin_i,
  input wire logic addr_select_lo_pin_i,
  // Four-wire pins
  input wire logic four_wire_clock_i,
  input wire logic four_wire_latch_i,
  input wire logic four_wire_serial_in_i,
  input wire logic four_wire_serial_out_o,
  input wire logic four_wire_serial_out_oe_o,
  // Register space and status
  input wire cdcp_pkg::cdcp_reg_req_t reg_req_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic four_wire_mode_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_in_frame;
    !four_wire_latch_i && four_wire_mode_o;
  endsequence
  sequence s_latch_idle;
    four_wire_latch_i [*3];
  endsequence

  property p_open_drain;
    i2c_sda_oe_o |-> !i2c_sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin driven high");
  // Data may only move while the clock is low, else it forms start or stop
  property p_scl_high;
    i2c_scl_i && $past(i2c_scl_i) |-> $stable(i2c_sda_oe_o);
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("data moved while clock high");
  property p_mode_sticky;
    four_wire_mode_o |=> four_wire_mode_o;
  endproperty
  a_mode_sticky: assert property (p_mode_sticky)
    else $error("left four-wire mode");
  property p_mode_rise;
    $rose(four_wire_mode_o) |-> four_wire_latch_i;
  endproperty
  a_mode_rise: assert property (p_mode_rise)
    else $error("mode set inside a latch pulse");
  property p_quiet;
    four_wire_mode_o |-> !i2c_sda_oe_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("two-wire answer in four-wire mode");
  property p_out_mode;
    four_wire_serial_out_oe_o |-> four_wire_mode_o;
  endproperty
  a_out_mode: assert property (p_out_mode)
    else $error("serial out driven outside mode");
  property p_out_frame;
    $rose(four_wire_serial_out_oe_o) |-> s_in_frame;
  endproperty
  a_out_frame: assert property (p_out_frame)
    else $error("serial out driven outside frame");
  property p_latch_idle;
    s_latch_idle |-> !four_wire_serial_out_oe_o;
  endproperty
  a_latch_idle: assert property (p_latch_idle)
    else $error("serial out driven with latch high");
  property p_wr_pulse;
    reg_req_o.wr |=> !reg_req_o.wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  property p_wr_range;
    reg_req_o.wr |-> reg_req_o.addr <= cdcp_pkg::TOP_SUBADDR;
  endproperty
  a_wr_range: assert property (p_wr_range)
    else $error("write above top subaddress");
  property p_idx;
    reg_req_o.byte_idx != 3'h0 |-> reg_req_o.addr == cdcp_pkg::PLL_CTRL_ADDR
      && reg_req_o.byte_idx < cdcp_pkg::PLL_CTRL_LEN;
  endproperty
  a_idx: assert property (p_idx)
    else $error("byte index outside the wide word");
endmodule : cdcp_control_port_sva

bind cdcp_control_port cdcp_control_port_sva u_sva (
  .mclk_i, .reset_n_i, .i2c_scl_i, .i2c_sda_i, .i2c_sda_o, .i2c_sda_oe_o,
  .addr_select_hi_pin_i, .addr_select_lo_pin_i, .four_wire_clock_i,
  .four_wire_latch_i, .four_wire_serial_in_i, .four_wire_serial_out_o,
  .four_wire_serial_out_oe_o, .reg_req_o, .reg_rdata_i, .four_wire_mode_o
);

`default_nettype wire

// [sim/cdcp_host_model.sv]
/*
  Host master for both control modes on the shared pins.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none

module cdcp_host_model (
  // Clock
  input wire logic mclk_i,
  // Shared pins
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic pin_hi_o,
  output logic pin_lo_o
);
  // ****************************************
  // Pin tasks
  // ****************************************
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    pin_hi_o = 1'b0;
    pin_lo_o = 1'b1;
  end

  // Quarter bit; slow enough for the two-flop pin sampling
  task q;
    repeat (10) @(posedge mclk_i);
  endtask : q

  task i2c_start;
    sda_low_o <= 1'b0;
    q;
    scl_o <= 1'b1;
    q;
    sda_low_o <= 1'b1;
    q;
    scl_o <= 1'b0;
    q;
  endtask : i2c_start

  task i2c_stop;
    sda_low_o <= 1'b1;
    q;
    scl_o <= 1'b1;
    q;
    sda_low_o <= 1'b0;
    q;
  endtask : i2c_stop

  task bit_io(input logic b, output logic r);
    sda_low_o <= !b;
    q;
    scl_o <= 1'b1;
    q;
    r = sda_line_i;
    q;
    scl_o <= 1'b0;
    q;
  endtask : bit_io

  task byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : byte_w

  task byte_r(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask : byte_r

  task latch(input logic lvl);
    #20 pin_lo_o <= lvl;
    #200;
  endtask : latch

  task sel(input logic lvl);
    pin_hi_o <= lvl;
    q;
  endtask : sel

  // Pause after each byte lets the port fetch before the next fall
  task spi_byte(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      #6 scl_o <= 1'b0;
      pin_hi_o <= d[i];
      #6 scl_o <= 1'b1;
      r[i] = sda_line_i;
    end
    #300;
  endtask : spi_byte
endmodule : cdcp_host_model

`default_nettype wire

// [sim/tb_top.sv]
/*
  Self-checking bench of the codec control port with a host model.
  Assumes the checker is bound through its own file.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ****************************************
  // Bench
  // ****************************************
  localparam logic [7:0] AW = {cdcp_pkg::I2C_ADDR_FIXED, 2'b01, 1'b0};
  localparam logic [7:0] AR = AW | 8'h01;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic scl, sda_low, pin_hi, pin_lo, sda_line;
  logic sda_o, sda_oe, out, out_oe, mode;
  cdcp_pkg::cdcp_reg_req_t req;
  logic [7:0] rdata;
  logic [26:0] wq[$];
  int n_errors = 0;
  int checks_done = 0;

  always #10 mclk = ~mclk;
  assign sda_line = out_oe ? out : !(sda_low | (sda_oe & !sda_o));
  assign rdata = req.addr[7:0] + {5'h0, req.byte_idx};
  always @(posedge mclk)
    if (req.wr)
      wq.push_back({req.addr, req.byte_idx, req.wdata});

  cdcp_host_model host (
    .mclk_i(mclk),
    .sda_line_i(sda_line),
    .scl_o(scl),
    .sda_low_o(sda_low),
    .pin_hi_o(pin_hi),
    .pin_lo_o(pin_lo)
  );

  cdcp_control_port dut (
    .mclk_i(mclk),
    .reset_n_i(reset_n),
    .i2c_scl_i(scl),
    .i2c_sda_i(sda_line),
    .i2c_sda_o(sda_o),
    .i2c_sda_oe_o(sda_oe),
    .addr_select_hi_pin_i(pin_hi),
    .addr_select_lo_pin_i(pin_lo),
    .four_wire_clock_i(scl),
    .four_wire_latch_i(pin_lo),
    .four_wire_serial_in_i(pin_hi),
    .four_wire_serial_out_o(out),
    .four_wire_serial_out_oe_o(out_oe),
    .reg_req_o(req),
    .reg_rdata_i(rdata),
    .four_wire_mode_o(mode)
  );

  task complete_run;
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : cmp_bit

  task cmp_val(input logic [26:0] got, input logic [26:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: value %h not %h", $time, got, exp);
    end
  endtask : cmp_val

  task send(input logic [7:0] d, input logic ack);
    logic a;
    host.byte_w(d, a);
    cmp_bit(a, ack);
  endtask : send

  task recv(input logic [7:0] exp, input logic mack);
    logic [7:0] d;
    host.byte_r(mack, d);
    cmp_val(27'(d), 27'(exp));
  endtask : recv

  task wr_rec(input logic [15:0] a, input logic [2:0] i, input logic [7:0] d);
    logic [26:0] g;
    g = 27'bx;
    if (wq.size() > 0)
      g = wq.pop_front();
    cmp_val(g, {a, i, d});
  endtask : wr_rec

  task t_i2c_write;
    host.i2c_start;
    send(AW, 1'b1);
    send(8'h40, 1'b1);
    send(8'h08, 1'b1);
    send(8'ha5, 1'b1);
    send(8'h3c, 1'b1);
    host.i2c_stop;
    wr_rec(16'h4008, 3'h0, 8'ha5);
    wr_rec(16'h4009, 3'h0, 8'h3c);
  endtask : t_i2c_write

  task t_i2c_refused;
    logic a;
    host.i2c_start;
    send(AW ^ 8'h04, 1'b0);
    send(8'h40, 1'b0);
    host.i2c_stop;
    host.sel(1'b1);
    host.i2c_start;
    send(AW ^ 8'h04, 1'b1);
    host.i2c_stop;
    host.sel(1'b0);
    host.i2c_start;
    send(AW, 1'b1);
    host.byte_w(8'h41, a);
    send(8'h00, 1'b0);
    send(8'h11, 1'b0);
    host.i2c_stop;
    cmp_val(27'(wq.size()), 27'h0);
  endtask : t_i2c_refused

  task t_i2c_restart;
    host.i2c_start;
    send(AW, 1'b1);
    send(8'h40, 1'b1);
    host.i2c_start;
    send(AW, 1'b1);
    send(8'h40, 1'b1);
    send(8'h09, 1'b1);
    send(8'h77, 1'b1);
    host.i2c_stop;
    wr_rec(16'h4009, 3'h0, 8'h77);
  endtask : t_i2c_restart

  task t_i2c_read_wide;
    host.i2c_start;
    send(AW, 1'b1);
    send(8'h40, 1'b1);
    send(8'h02, 1'b1);
    host.i2c_start;
    send(AR, 1'b1);
    for (int i = 0; i < 6; i++)
      recv(8'h02 + 8'(i), 1'b1);
    recv(cdcp_pkg::HOLE_DATA, 1'b0);
    host.i2c_stop;
  endtask : t_i2c_read_wide

  task t_i2c_top;
    host.i2c_start;
    send(AW, 1'b1);
    send(8'h40, 1'b1);
    send(8'hff, 1'b1);
    host.i2c_start;
    send(AR, 1'b1);
    recv(8'hff, 1'b1);
    recv(8'hff, 1'b1);
    recv(8'hff, 1'b0);
    host.i2c_stop;
    host.i2c_start;
    send(AW, 1'b1);
    send(8'h40, 1'b1);
    send(8'hff, 1'b1);
    send(8'h5a, 1'b1);
    send(8'h6b, 1'b0);
    host.i2c_stop;
    wr_rec(16'h40ff, 3'h0, 8'h5a);
    cmp_val(27'(wq.size()), 27'h0);
  endtask : t_i2c_top

  task t_mode_switch;
    logic [7:0] r;
    for (int k = 1; k <= 3; k++)
    begin
      host.latch(1'b0);
      host.spi_byte(8'h00, r);
      host.latch(1'b1);
      cmp_bit(mode, k == 3);
    end
  endtask : t_mode_switch

  task t_spi;
    logic [7:0] r;
    host.latch(1'b0);
    host.spi_byte(8'h00, r);
    cmp_val(27'(r), 27'hff);
    host.spi_byte(8'h40, r);
    host.spi_byte(8'h0a, r);
    host.spi_byte(8'h96, r);
    host.spi_byte(8'h69, r);
    host.latch(1'b1);
    wr_rec(16'h400a, 3'h0, 8'h96);
    wr_rec(16'h400b, 3'h0, 8'h69);
    host.latch(1'b0);
    host.spi_byte(8'h01, r);
    host.spi_byte(8'h40, r);
    host.spi_byte(8'h02, r);
    cmp_bit(out_oe, 1'b0);
    host.spi_byte(8'h00, r);
    cmp_val(27'(r), 27'h02);
    host.spi_byte(8'h00, r);
    cmp_val(27'(r), 27'h03);
    host.latch(1'b1);
    host.latch(1'b0);
    host.spi_byte(8'h02, r);
    host.spi_byte(8'h40, r);
    host.spi_byte(8'h0c, r);
    host.spi_byte(8'h55, r);
    host.latch(1'b1);
    cmp_val(27'(wq.size()), 27'h0);
  endtask : t_spi

  task t_i2c_after;
    host.i2c_start;
    send(AW, 1'b0);
    host.i2c_stop;
    cmp_bit(mode, 1'b1);
  endtask : t_i2c_after

  initial
  begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (5) @(posedge mclk);
    t_i2c_write;
    t_i2c_refused;
    t_i2c_restart;
    t_i2c_read_wide;
    t_i2c_top;
    t_mode_switch;
    t_spi;
    t_i2c_after;
    complete_run;
  end

  // Tests need about 0.32 ms; allow about three times that
  initial
  begin
    #1000000;
    n_errors++;
    complete_run;
  end
endmodule : tb_top

`default_nettype wire
